// *** tb/cic_core_interrupt_control_properties.sv ***
// checker of the interrupt control block ports
`timescale 1ns/1ps
module cic_core_interrupt_control_properties (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        vector_taken_i,
  input wire logic        return_from_interrupt_i,
  input wire logic        vector_req_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic        push_pc_o,
  input wire logic        restore_context_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_rdata_idle:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not idle");
  a_unmapped_read:
    assert property (rd_i && addr_i > 4'h6 |=> rdata_o == 8'h00) else $error("unmapped read");
  a_push_pulse:
    assert property (push_pc_o |=> !push_pc_o) else $error("push pulse too long");
  a_accept_vector:
    assert property ($rose(vector_req_o) |-> push_pc_o && vector_addr_o == 16'h0004)
      else $error("accept without push or vector");
  a_req_holds:
    assert property (vector_req_o && !vector_taken_i |=> vector_req_o) else $error("req dropped");
  a_req_release:
    assert property (vector_req_o && vector_taken_i |=> !vector_req_o) else $error("req stuck");
  a_one_accept:
    assert property (push_pc_o |-> !$past(vector_req_o)) else $error("accept while pending");
  a_restore_cause:
    assert property (restore_context_o |-> $past(return_from_interrupt_i) && !$past(vector_req_o))
      else $error("restore without return");
  a_reset_outputs:
    assert property ($rose(reset_n_i) |-> !vector_req_o && !irq_o && vector_addr_o == 16'h0000)
      else $error("outputs not cleared by reset");
endmodule

bind cic_core_interrupt_control cic_core_interrupt_control_properties chk_u (
  .ref_clk_i, .reset_n_i, .addr_i, .rd_i, .rdata_o, .vector_taken_i, .return_from_interrupt_i,
  .vector_req_o, .vector_addr_o, .push_pc_o, .restore_context_o, .irq_o);

// *** tb/cic_seq_model.sv ***
// program sequencer model: takes the vector after a delay, returns on command
`timescale 1ns/1ps
module cic_seq_model (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       vector_req_i,
  input  wire logic       ret_cmd_i,
  input  wire logic [2:0] delay_i,
  output logic            vector_taken_o,
  output logic            return_o
);
  int wait_cnt;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      {vector_taken_o, return_o, wait_cnt} <= '0;
    end else begin
      return_o <= ret_cmd_i;
      vector_taken_o <= 1'b0;
      // slow answers keep the request standing several cycles
      if (vector_req_i && !vector_taken_o) begin
        wait_cnt <= (wait_cnt >= delay_i) ? 0 : wait_cnt + 1;
        vector_taken_o <= (wait_cnt >= delay_i);
      end
    end
  end
endmodule

// *** tb/core_interrupt_control_tb.sv ***
// self-checking bench of the interrupt control block
`timescale 1ns/1ps
module core_interrupt_control_tb;
  logic ref_clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, timer_overflow_i = 0, ext_pin_i = 0;
  logic external_edge_select_i = 0, peripheral_req_i = 0, ret_cmd = 0;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, change_pins_i = 0, rdata_o;
  logic [2:0] delay = 0;
  logic vector_taken_i, return_from_interrupt_i, vector_req_o, push_pc_o, restore_context_o, irq_o;
  logic [15:0] vector_addr_o;
  logic [31:0] seed = 32'd93397;
  int failures = 0, samples_checked = 0, pushes = 0, restores = 0, m_ctl = 0, m_pins = 0, p;
  int tab [6][4] = '{'{8'h40,1,0,0}, '{8'h80,1,0,0}, '{8'hc0,1,0,1}, '{8'ha0,0,1,1},
                     '{8'h80,0,1,0}, '{8'h20,0,1,0}};
  always #4 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i) begin
    pushes += push_pc_o;
    restores += restore_context_o;
  end
  cic_core_interrupt_control dut_u (.ref_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .timer_overflow_i, .ext_pin_i, .external_edge_select_i, .change_pins_i,
    .peripheral_req_i, .vector_taken_i, .return_from_interrupt_i, .vector_req_o,
    .vector_addr_o, .push_pc_o, .restore_context_o, .irq_o);
  cic_seq_model seq_u (.ref_clk_i, .reset_n_i, .vector_req_i(vector_req_o), .ret_cmd_i(ret_cmd),
    .delay_i(delay), .vector_taken_o(vector_taken_i), .return_o(return_from_interrupt_i));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    t = t ^ (t << 5);
    return t;
  endfunction
  task automatic rnd();
    seed = xorshift(seed);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 check({8'h00, rdata_o}, {8'h00, exp});
  endtask
  task automatic ctlw(input int d);
    wr(4'h0, d[7:0]);
    m_ctl = d & 8'hfe;
  endtask
  task automatic ctl_chk();
    rd(4'h0, 8'(m_ctl | (m_pins != 0)));
  endtask
  task automatic tmr();
    @(posedge ref_clk_i) timer_overflow_i <= 1'b1;
    @(posedge ref_clk_i) timer_overflow_i <= 1'b0;
    m_ctl |= 4;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    step(20000);
    failures++;
    report_and_stop();
  end
  initial begin
    step(20);
    reset_n_i <= 1'b1;
    ctl_chk();
    rnd();
    wr(4'hf, seed[7:0]);
    rd(4'hf, 8'h00);
    tmr();
    step(3);
    ctl_chk();
    for (int s = 0; s < 2; s++) begin
      external_edge_select_i <= s[0];
      for (int v = 1; v >= 0; v--) begin
        ext_pin_i <= v[0];
        step(5);
        if (v == s) m_ctl |= 2;
        ctl_chk();
        ctlw(0);
      end
    end
    rnd();
    p = seed % 8;
    wr(4'h4, 8'(1 << p));
    change_pins_i <= 8'(1 << p) | 8'(1 << ((p + 1) % 8));
    step(5);
    m_pins = 1 << p;
    rd(4'h3, m_pins[7:0]);
    ctlw(8'h01);
    ctl_chk();
    wr(4'h3, 8'h00);
    m_pins = 0;
    ctlw(8'h01);
    ctl_chk();
    foreach (tab[i]) begin
      rnd();
      delay <= seed[2:0];
      p = pushes;
      ctlw(tab[i][0]);
      peripheral_req_i <= tab[i][1][0];
      if (tab[i][2] != 0) tmr();
      step(4);
      check(16'(pushes), 16'(p + tab[i][3]));
      peripheral_req_i <= 1'b0;
      if (tab[i][3] != 0) begin
        check(vector_addr_o, 16'h0004);
        m_ctl &= 8'h7f;
        ctl_chk();
        for (int k = 0; k < 20 && vector_req_o; k++) step(1);
        ctlw(0);
        p = restores;
        @(posedge ref_clk_i) ret_cmd <= 1'b1;
        @(posedge ref_clk_i) ret_cmd <= 1'b0;
        step(3);
        m_ctl = 8'h80;
        check(16'(restores), 16'(p + 1));
        ctl_chk();
      end
    end
    ctlw(8'h20);
    tmr();
    wr(4'h2, 8'h04);
    step(2);
    check({15'h0, irq_o}, 16'h0001);
    rd(4'h1, 8'h04);
    wr(4'h2, 8'h00);
    step(2);
    check({15'h0, irq_o}, 16'h0000);
    ctlw(0);
    wr(4'h1, 8'h04);
    rd(4'h1, 8'h00);
    report_and_stop();
  end
endmodule

// *** verilog/cic_core_interrupt_control.sv ***
// core interrupt control register, source flags and vector request logic
//
// Contract
// [RQ1] global enable one lets enabled interrupts redirect; zero blocks all
// [RQ2] peripheral-group enable passes enabled peripheral requests to global gate
// [RQ3] clearing peripheral-group enable blocks every peripheral source
// [RQ4] timer-overflow flag sets on 8-bit timer overflow, else reads zero
// [RQ5] external-pin flag sets on qualifying pin edge, else stays zero
// [RQ6] pin-change summary is one while any per-pin change flag is set
// [RQ7] summary is read-only; clears only when all per-pin flags cleared
// [RQ8] every implemented control bit resets to zero
// [RQ9] flags set on events regardless of any enable bit; per-pin change flags here set only for pins enabled in pin_change_enable
// [RQ10] accepting interrupt clears global enable, pushes pc, loads vector
// [RQ11] return from interrupt restores context and sets global enable
// [RQ12] edge select one picks rising edge, zero picks falling edge
// [RQ13] each source requests only when its flag and enable are both one
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "cic_regs.svh"

module cic_core_interrupt_control (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  // register port
  input  wire logic [`CIC_ADDR_W-1:0]    addr_i,
  input  wire logic [7:0]                wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [7:0]                rdata_o,
  // event sources
  input  wire logic                      timer_overflow_i,
  input  wire logic                      ext_pin_i,
  input  wire logic                      external_edge_select_i,
  input  wire logic [`CIC_PIN_COUNT-1:0] change_pins_i,
  input  wire logic                      peripheral_req_i,
  // program sequencer
  input  wire logic                      vector_taken_i,
  input  wire logic                      return_from_interrupt_i,
  output logic                           vector_req_o,
  output logic      [15:0]               vector_addr_o,
  output logic                           push_pc_o,
  output logic                           restore_context_o,
  // interrupt line
  output logic                           irq_o
);

  // ----------------------------------------------------------------
  // control register and per-pin change state
  // ----------------------------------------------------------------
  logic                      global_irq_enable;
  logic                      peripheral_group_enable;
  logic                      timer_overflow_irq_enable;
  logic                      ext_irq_enable;
  logic                      pin_change_irq_enable;
  logic                      timer_overflow_flag;
  logic                      external_pin_flag;
  logic [`CIC_PIN_COUNT-1:0] per_pin_change_flags;
  logic [`CIC_PIN_COUNT-1:0] pin_change_enable;
  logic [2:0]                irq_status;
  logic [2:0]                irq_mask;
  cic_pkg::cic_state_e       state;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic                      ext_meta;
  logic                      ext_sync;
  logic                      ext_prev;
  logic [`CIC_PIN_COUNT-1:0] pins_meta;
  logic [`CIC_PIN_COUNT-1:0] pins_sync;
  logic [`CIC_PIN_COUNT-1:0] pins_prev;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ext_meta  <= 1'b0;
      ext_sync  <= 1'b0;
      ext_prev  <= 1'b0;
      pins_meta <= 8'h00;
      pins_sync <= 8'h00;
      pins_prev <= 8'h00;
    end else begin
      ext_meta  <= ext_pin_i;
      ext_sync  <= ext_meta;
      ext_prev  <= ext_sync;
      pins_meta <= change_pins_i;
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  // edge detection starts from the synced copy; a pin held high through reset gives one rising edge
  wire ext_rise  = ext_sync & ~ext_prev;
  wire ext_fall  = ~ext_sync & ext_prev;
  wire ext_event = external_edge_select_i ? ext_rise : ext_fall; // [RQ12]
  wire [`CIC_PIN_COUNT-1:0] pin_events = (pins_sync ^ pins_prev) & pin_change_enable;

  wire pin_change_summary_flag = |per_pin_change_flags; // [RQ6]

  wire wr_control = wr_i && (addr_i == `CIC_OFF_CONTROL);
  wire wr_status  = wr_i && (addr_i == `CIC_OFF_IRQ_STATUS);
  wire wr_mask    = wr_i && (addr_i == `CIC_OFF_IRQ_MASK);
  wire wr_pflags  = wr_i && (addr_i == `CIC_OFF_PIN_FLAGS);
  wire wr_penable = wr_i && (addr_i == `CIC_OFF_PIN_ENABLE);

  wire [7:0] control_value = {global_irq_enable, peripheral_group_enable,
                              timer_overflow_irq_enable, ext_irq_enable,
                              pin_change_irq_enable, timer_overflow_flag,
                              external_pin_flag, pin_change_summary_flag};

  // ----------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------
  wire tmr_req = timer_overflow_flag & timer_overflow_irq_enable;     // [RQ13]
  wire ext_req = external_pin_flag & ext_irq_enable;                  // [RQ13]
  wire pc_req  = pin_change_summary_flag & pin_change_irq_enable;     // [RQ13]
  wire per_req = peripheral_req_i & peripheral_group_enable;          // [RQ2] [RQ3]
  wire any_req = tmr_req | ext_req | pc_req | per_req;
  wire accept  = global_irq_enable & any_req & (state == cic_pkg::CIC_RUN); // [RQ1]

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      `CIC_OFF_CONTROL:    next_rdata = control_value;
      `CIC_OFF_IRQ_STATUS: next_rdata = {5'h00, irq_status};
      `CIC_OFF_IRQ_MASK:   next_rdata = {5'h00, irq_mask};
      `CIC_OFF_PIN_FLAGS:  next_rdata = per_pin_change_flags;
      `CIC_OFF_PIN_ENABLE: next_rdata = pin_change_enable;
      `CIC_OFF_VECTOR_LO:  next_rdata = vector_addr_o[7:0];
      `CIC_OFF_VECTOR_HI:  next_rdata = vector_addr_o[15:8];
      default:             next_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // hardware sets beat a software write of zero in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      global_irq_enable         <= 1'b0; // [RQ8]
      peripheral_group_enable   <= 1'b0;
      timer_overflow_irq_enable <= 1'b0;
      ext_irq_enable            <= 1'b0;
      pin_change_irq_enable     <= 1'b0;
      timer_overflow_flag       <= 1'b0;
      external_pin_flag         <= 1'b0;
      per_pin_change_flags      <= 8'h00;
      pin_change_enable         <= 8'h00;
    end else begin
      if (accept) begin
        global_irq_enable <= 1'b0; // [RQ10]
      end else if (return_from_interrupt_i && state == cic_pkg::CIC_IN_ISR) begin
        global_irq_enable <= 1'b1; // [RQ11]
      end else if (wr_control) begin
        global_irq_enable <= wdata_i[`CIC_BIT_GLOBAL_EN];
      end
      if (wr_control) begin
        peripheral_group_enable   <= wdata_i[`CIC_BIT_PERIPH_EN];
        timer_overflow_irq_enable <= wdata_i[`CIC_BIT_TMR_IE];
        ext_irq_enable            <= wdata_i[`CIC_BIT_EXT_IE];
        pin_change_irq_enable     <= wdata_i[`CIC_BIT_PC_IE];
      end
      // flags set with no regard to any enable bit
      timer_overflow_flag <= timer_overflow_i |
                             (wr_control ? wdata_i[`CIC_BIT_TMR_F] : timer_overflow_flag); // [RQ4] [RQ9]
      external_pin_flag   <= ext_event |
                             (wr_control ? wdata_i[`CIC_BIT_EXT_F] : external_pin_flag); // [RQ5] [RQ9]
      // summary bit ignores control writes; only per-pin flags are writable
      per_pin_change_flags <= pin_events |
                              (wr_pflags ? wdata_i : per_pin_change_flags); // [RQ7]; per-pin flags set only for pins enabled in pin_change_enable
      if (wr_penable) begin
        pin_change_enable <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky status, mask and sequencer handshake
  // ----------------------------------------------------------------
  wire [2:0] status_set = {tmr_req, ext_req, pc_req};
  wire [2:0] next_status = status_set | (irq_status & ~(wr_status ? wdata_i[2:0] : 3'h0));

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_status        <= 3'h0;
      irq_mask          <= 3'h0;
      irq_o             <= 1'b0;
      rdata_o           <= 8'h00;
      state             <= cic_pkg::CIC_RUN;
      vector_req_o      <= 1'b0;
      vector_addr_o     <= 16'h0000;
      push_pc_o         <= 1'b0;
      restore_context_o <= 1'b0;
    end else begin
      irq_status        <= next_status;
      irq_o             <= |(next_status & (wr_mask ? wdata_i[2:0] : irq_mask));
      rdata_o           <= rd_i ? next_rdata : 8'h00;
      push_pc_o         <= accept; // [RQ10]
      restore_context_o <= return_from_interrupt_i && state == cic_pkg::CIC_IN_ISR; // [RQ11]
      if (wr_mask) begin
        irq_mask <= wdata_i[2:0];
      end
      case (state)
        cic_pkg::CIC_RUN: begin
          if (accept) begin
            state         <= cic_pkg::CIC_VECTOR;
            vector_req_o  <= 1'b1;
            vector_addr_o <= `CIC_VECTOR; // [RQ10]
          end
        end
        cic_pkg::CIC_VECTOR: begin
          if (vector_taken_i) begin
            state        <= cic_pkg::CIC_IN_ISR;
            vector_req_o <= 1'b0;
          end
        end
        cic_pkg::CIC_IN_ISR: begin
          if (return_from_interrupt_i) begin
            state <= cic_pkg::CIC_RUN;
          end
        end
        default: begin
          state <= cic_pkg::CIC_RUN;
        end
      endcase
    end
  end

endmodule

// *** verilog/cic_pkg.sv ***
// types shared by the interrupt control block
package cic_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cic_bus_s;

  typedef struct packed {
    logic timer_overflow;
    logic ext_level;
    logic peripheral_req;
  } cic_events_s;

  typedef enum logic [1:0] {
    CIC_RUN,
    CIC_VECTOR,
    CIC_IN_ISR
  } cic_state_e;

endpackage

// *** verilog/cic_regs.svh ***
// register offsets, field positions, reset values and counts of the interrupt control block
`ifndef CIC_REGS_SVH
`define CIC_REGS_SVH

`define CIC_ADDR_W          4
`define CIC_OFF_CONTROL     4'h0
`define CIC_OFF_IRQ_STATUS  4'h1
`define CIC_OFF_IRQ_MASK    4'h2
`define CIC_OFF_PIN_FLAGS   4'h3
`define CIC_OFF_PIN_ENABLE  4'h4
`define CIC_OFF_VECTOR_LO   4'h5
`define CIC_OFF_VECTOR_HI   4'h6

`define CIC_BIT_GLOBAL_EN   7
`define CIC_BIT_PERIPH_EN   6
`define CIC_BIT_TMR_IE      5
`define CIC_BIT_EXT_IE      4
`define CIC_BIT_PC_IE       3
`define CIC_BIT_TMR_F       2
`define CIC_BIT_EXT_F       1
`define CIC_BIT_PC_F        0

`define CIC_RESET_CONTROL   8'h00
`define CIC_VECTOR          16'h0004
`define CIC_PIN_COUNT       8

`endif
